/* core/pmc_core.sv */
// pmc_core: cpu clock divide, clock source, idle and stop control
// assumes: clock i_clk is the crystal clock domain; ring and crystal
// oscillators are analog, steered by the outputs of this module.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps

// Overview of operation
// - source select 1=crystal, 0=ring; 0 to 1 only if stable and enabled
// - ring active status reads 1 while cpu runs on ring; reset 0
// - divide field 01=4, 10=64, 11=1024 clocks per cycle; reset 01
// - writes of 10 or 11 accepted only while field holds 01
// - switchback enable returns divide to 4 clocks by hardware
// - crystal disable stops crystal; set only while source is ring
// - power-fail, high and low priority in-service flags, read only
// - crystal stable flag reads 1 once crystal settles; reset 1
// - four serial activity flags for both ports, read only, reset 0
// - power control bit 0 enters idle; cpu halts, clocks run
// - idle ends on any interrupt or reset
// - power control bit 1 enters stop; clocks and crystal off
// - stop ends on external or clock interrupt, or reset
// - bandgap in stop keeps reference powered during stop
// - with bandgap on, power-fail interrupt wakes from stop
// - bandgap in stop has no effect outside stop
// - ring wake select runs cpu from ring right after stop
// - after ring wake, count crystal clocks then return to crystal
module pmc_core #(
    parameter int XTAL_START_CLOCKS = pmc_pkg::PMC_XTAL_START_CLOCKS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [9:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // wake and status sources
    input wire logic i_any_irq,
    input wire logic i_ext_irq,
    input wire logic i_rtc_irq,
    input wire logic i_powerfail_irq,
    input wire logic i_powerfail_in_service,
    input wire logic i_high_prio_in_service,
    input wire logic i_low_prio_in_service,
    input wire logic i_port1_tx_active,
    input wire logic i_port1_rx_active,
    input wire logic i_port0_tx_active,
    input wire logic i_port0_rx_active,
    // clock control outputs
    output logic o_cpu_halt,
    output logic o_clocks_gated,
    output logic o_crystal_enable,
    output logic o_bandgap_enable,
    output logic o_ring_active_flag,
    output logic [1:0] o_clock_divide_select,
    output logic o_machine_cycle_strobe
);

    if (XTAL_START_CLOCKS < 1) begin : g_bad_start
        $error("XTAL_START_CLOCKS must be at least one");
    end

    localparam int CW = $clog2(XTAL_START_CLOCKS + 1);
    localparam logic [CW-1:0] START_LAST = CW'(XTAL_START_CLOCKS - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pmc_pkg::pmc_mode_e mode;
    logic clock_source_select;
    logic ring_active_flag;
    logic [1:0] clock_divide_select;
    logic auto_switchback_enable;
    logic crystal_disable;
    logic bandgap_in_stop;
    logic ring_wake_select;
    logic crystal_stable_flag;
    logic [CW-1:0] start_count;
    logic [9:0] cyc_count;

    logic wr;
    logic [7:0] wdat;
    logic [1:0] wdiv;
    logic wake_idle;
    logic wake_stop;
    logic crystal_running;
    logic [9:0] cyc_last;

    function automatic logic hit(input logic [9:0] adr,
                                 input logic [9:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction : hit

    // writes land on the edge after the one that presents ack to the master
    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
    assign wdat = i_wb_dat[7:0];
    assign wdiv = wdat[pmc_pkg::PMC_PM_DIV_LO +: 2];

    // ------------------------------------------------------------
    // wake conditions
    // ------------------------------------------------------------
    assign wake_idle = i_any_irq;
    assign wake_stop = i_ext_irq | i_rtc_irq
                       | (bandgap_in_stop & i_powerfail_irq);

    // ------------------------------------------------------------
    // mode machine
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            mode <= pmc_pkg::PMC_RUN;
        end else begin
            case (mode)
                pmc_pkg::PMC_RUN: begin
                    if (wr && hit(i_wb_adr,
                                  pmc_pkg::PMC_ADR_POWER_CONTROL)) begin
                        if (wdat[pmc_pkg::PMC_PC_STOP]) begin
                            mode <= pmc_pkg::PMC_STOP;
                        end else if (wdat[pmc_pkg::PMC_PC_IDLE]) begin
                            mode <= pmc_pkg::PMC_IDLE;
                        end
                    end
                end
                pmc_pkg::PMC_IDLE: begin
                    if (wake_idle) begin
                        mode <= pmc_pkg::PMC_RUN;
                    end
                end
                pmc_pkg::PMC_STOP: begin
                    if (wake_stop) begin
                        mode <= pmc_pkg::PMC_RUN;
                    end
                end
                default: mode <= pmc_pkg::PMC_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock divide field and switchback
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            clock_divide_select <= pmc_pkg::PMC_RST_DIV;
        end else if (auto_switchback_enable && (i_any_irq
                     || i_port0_rx_active || i_port1_rx_active
                     || i_port0_tx_active || i_port1_tx_active)) begin
            clock_divide_select <= pmc_pkg::PMC_DIV_4;
        end else if (wr && hit(i_wb_adr, pmc_pkg::PMC_ADR_POWER_MODE)) begin
            if (wdiv == pmc_pkg::PMC_DIV_4) begin
                clock_divide_select <= pmc_pkg::PMC_DIV_4;
            end else if (wdiv != 2'h0
                         && clock_divide_select == pmc_pkg::PMC_DIV_4) begin
                clock_divide_select <= wdiv;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            auto_switchback_enable <= 1'b0;
        end else if (wr && hit(i_wb_adr, pmc_pkg::PMC_ADR_POWER_MODE)) begin
            auto_switchback_enable <=
                wdat[pmc_pkg::PMC_PM_SWITCHBACK];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            crystal_disable <= 1'b0;
        end else if (wr && hit(i_wb_adr, pmc_pkg::PMC_ADR_POWER_MODE)) begin
            if (!wdat[pmc_pkg::PMC_PM_XOFF]) begin
                crystal_disable <= 1'b0;
            end else if (!clock_source_select) begin
                crystal_disable <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // extended flag register: source, ring wake, bandgap
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            bandgap_in_stop <= 1'b0;
            ring_wake_select <= 1'b0;
        end else if (wr && hit(i_wb_adr, pmc_pkg::PMC_ADR_EXT_FLAG)) begin
            bandgap_in_stop <= wdat[pmc_pkg::PMC_EX_BANDGAP];
            ring_wake_select <= wdat[pmc_pkg::PMC_EX_RING_WAKE];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            clock_source_select <= pmc_pkg::PMC_RST_SOURCE;
        end else if (wr && hit(i_wb_adr, pmc_pkg::PMC_ADR_EXT_FLAG)) begin
            if (!wdat[pmc_pkg::PMC_EX_SOURCE]) begin
                clock_source_select <= 1'b0;
            end else if (crystal_stable_flag && !crystal_disable) begin
                clock_source_select <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // ring mode after stop and crystal start-up count
    // ------------------------------------------------------------
    assign crystal_running = (mode != pmc_pkg::PMC_STOP) & ~crystal_disable;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            crystal_stable_flag <= pmc_pkg::PMC_RST_XSTABLE;
            start_count <= '0;
        end else if (!crystal_running) begin
            crystal_stable_flag <= 1'b0;
            start_count <= '0;
        end else if (!crystal_stable_flag) begin
            if (start_count == START_LAST) begin
                crystal_stable_flag <= 1'b1;
            end
            start_count <= start_count + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ring_active_flag <= 1'b0;
        end else if (mode == pmc_pkg::PMC_STOP && wake_stop) begin
            ring_active_flag <= ring_wake_select
                                | ~clock_source_select;
        end else if (clock_source_select && crystal_stable_flag) begin
            ring_active_flag <= 1'b0;
        end else if (!clock_source_select) begin
            ring_active_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // machine cycle strobe from divide setting
    // ------------------------------------------------------------
    always_comb begin
        case (clock_divide_select)
            pmc_pkg::PMC_DIV_64: cyc_last = 10'(pmc_pkg::PMC_CYC_DIV_64 - 1);
            pmc_pkg::PMC_DIV_1024: begin
                cyc_last = 10'(pmc_pkg::PMC_CYC_DIV_1024 - 1);
            end
            default: cyc_last = 10'(pmc_pkg::PMC_CYC_DIV_4 - 1);
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cyc_count <= '0;
            o_machine_cycle_strobe <= 1'b0;
        end else if (mode == pmc_pkg::PMC_STOP) begin
            cyc_count <= '0;
            o_machine_cycle_strobe <= 1'b0;
        end else if (cyc_count >= cyc_last) begin
            cyc_count <= '0;
            o_machine_cycle_strobe <= 1'b1;
        end else begin
            cyc_count <= cyc_count + 1'b1;
            o_machine_cycle_strobe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_cpu_halt <= 1'b0;
            o_clocks_gated <= 1'b0;
            o_crystal_enable <= 1'b1;
            o_bandgap_enable <= 1'b1;
        end else begin
            o_cpu_halt <= (mode != pmc_pkg::PMC_RUN);
            o_clocks_gated <= (mode == pmc_pkg::PMC_STOP);
            o_crystal_enable <= crystal_running;
            o_bandgap_enable <= (mode != pmc_pkg::PMC_STOP)
                                | bandgap_in_stop;
        end
    end

    assign o_ring_active_flag = ring_active_flag;
    assign o_clock_divide_select = clock_divide_select;

    // ------------------------------------------------------------
    // wishbone read and acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end else begin
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
            o_wb_dat <= '0;
            if (hit(i_wb_adr, pmc_pkg::PMC_ADR_POWER_CONTROL)) begin
                o_wb_dat[1:0] <= {mode == pmc_pkg::PMC_STOP,
                                  mode == pmc_pkg::PMC_IDLE};
            end else if (hit(i_wb_adr, pmc_pkg::PMC_ADR_EXT_FLAG)) begin
                o_wb_dat[3:0] <= {clock_source_select, ring_active_flag,
                                  ring_wake_select, bandgap_in_stop};
            end else if (hit(i_wb_adr, pmc_pkg::PMC_ADR_POWER_MODE)) begin
                o_wb_dat[7:0] <= {clock_divide_select,
                                  auto_switchback_enable, 1'b0,
                                  crystal_disable, 3'h0};
            end else if (hit(i_wb_adr, pmc_pkg::PMC_ADR_CPU_STATE)) begin
                o_wb_dat[7:0] <= {i_powerfail_in_service,
                                  i_high_prio_in_service,
                                  i_low_prio_in_service,
                                  crystal_stable_flag,
                                  i_port1_tx_active, i_port1_rx_active,
                                  i_port0_tx_active,
                                  i_port0_rx_active};
            end
        end
    end

endmodule : pmc_core

/* pkg/pmc_pkg.sv */
// pmc_pkg: register map, field positions, reset values and counts
// for the power-mode clock controller.
// assumes: byte-addressed classic wishbone slave with 32-bit data.
package pmc_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] PMC_IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] PMC_IDX_EXT_FLAG = 8'h91;
    localparam logic [7:0] PMC_IDX_POWER_MODE = 8'hA0;
    localparam logic [7:0] PMC_IDX_CPU_STATE = 8'hA1;
    localparam logic [9:0] PMC_ADR_POWER_CONTROL =
        {PMC_IDX_POWER_CONTROL, 2'h0};
    localparam logic [9:0] PMC_ADR_EXT_FLAG = {PMC_IDX_EXT_FLAG, 2'h0};
    localparam logic [9:0] PMC_ADR_POWER_MODE = {PMC_IDX_POWER_MODE, 2'h0};
    localparam logic [9:0] PMC_ADR_CPU_STATE = {PMC_IDX_CPU_STATE, 2'h0};

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PMC_PC_IDLE = 0;
    localparam int PMC_PC_STOP = 1;
    localparam int PMC_EX_BANDGAP = 0;
    localparam int PMC_EX_RING_WAKE = 1;
    localparam int PMC_EX_RING_ACTIVE = 2;
    localparam int PMC_EX_SOURCE = 3;
    localparam int PMC_PM_DIV_LO = 6;
    localparam int PMC_PM_SWITCHBACK = 5;
    localparam int PMC_PM_XOFF = 3;
    localparam int PMC_ST_XSTABLE = 4;

    // ------------------------------------------------------------
    // divide encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PMC_DIV_4 = 2'h1;
    localparam logic [1:0] PMC_DIV_64 = 2'h2;
    localparam logic [1:0] PMC_DIV_1024 = 2'h3;
    localparam logic [1:0] PMC_RST_DIV = PMC_DIV_4;
    localparam logic PMC_RST_SOURCE = 1'b1;
    localparam logic PMC_RST_XSTABLE = 1'b1;
    localparam int PMC_CYC_DIV_4 = 4;
    localparam int PMC_CYC_DIV_64 = 64;
    localparam int PMC_CYC_DIV_1024 = 1024;

    // ------------------------------------------------------------
    // timing: crystal start-up interval in crystal clocks
    // ------------------------------------------------------------
    localparam int PMC_XTAL_START_CLOCKS = 65536;

    typedef enum logic [1:0] {
        PMC_RUN = 2'b00,
        PMC_IDLE = 2'b01,
        PMC_STOP = 2'b10
    } pmc_mode_e;

endpackage : pmc_pkg

/* tb/pmc_far_model.sv */
// pmc_far_model: interrupt sources and serial status around the core
// assumes: bench sets its requests just after a rising clock edge
`timescale 1ns/1ps
module pmc_far_model (
    // ring state from the core
    input wire logic i_ring,
    // bench requests
    input wire logic [6:0] i_st_req,
    input wire logic [3:0] i_irq_req,
    // lines into the core
    output logic [6:0] o_st,
    output logic o_any_irq,
    output logic o_ext_irq,
    output logic o_rtc_irq,
    output logic o_pf_irq
);
    // serial traffic held off while the cpu runs on the ring
    assign o_st = i_ring ? {i_st_req[6:4], 4'h0} : i_st_req;
    assign {o_pf_irq, o_rtc_irq, o_ext_irq, o_any_irq} = i_irq_req;
endmodule : pmc_far_model

/* tb/pmc_core_chk.sv */
// pmc_core_chk: port-level checks for the power-mode clock controller
// assumes: bound to pmc_core, one clock domain on i_clk
`timescale 1ns/1ps
module pmc_core_chk #(
    parameter int XTAL_START_CLOCKS = 16
) (
    // clock, reset and bus
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    // wake sources
    input wire logic i_any_irq,
    input wire logic i_ext_irq,
    input wire logic i_rtc_irq,
    input wire logic i_powerfail_irq,
    // clock control
    input wire logic o_cpu_halt,
    input wire logic o_clocks_gated,
    input wire logic o_crystal_enable,
    input wire logic o_bandgap_enable,
    input wire logic o_ring_active_flag,
    input wire logic [1:0] o_clock_divide_select,
    input wire logic o_machine_cycle_strobe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");
    a_ack_follows_req: assert property
        (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack after request");
    a_divide_code_legal: assert property
        (o_clock_divide_select != 2'h0) else $error("divide code 00");
    a_reduced_from_four: assert property
        ($changed(o_clock_divide_select) && o_clock_divide_select != 2'h1
        |-> $past(o_clock_divide_select) == 2'h1)
        else $error("reduced mode entered from other than 01");
    a_fast_strobe_gap: assert property
        (o_machine_cycle_strobe && o_clock_divide_select == 2'h1
        |=> !o_machine_cycle_strobe [*3] ##1 (o_machine_cycle_strobe
        || o_clock_divide_select != 2'h1 || o_cpu_halt))
        else $error("strobe period not 4 clocks");
    a_bandgap_out_stop: assert property
        (!o_clocks_gated && !$past(o_clocks_gated) |-> o_bandgap_enable)
        else $error("bandgap off outside stop");
    a_stop_all_off: assert property
        (o_clocks_gated && $past(o_clocks_gated)
        |-> o_cpu_halt && !o_crystal_enable)
        else $error("stop left cpu or crystal running");
    a_stop_holds: assert property
        (o_clocks_gated && !i_ext_irq && !i_rtc_irq
        && !(i_powerfail_irq && o_bandgap_enable) |=> o_clocks_gated)
        else $error("stop left without a wake source");
    a_ext_wakes_stop: assert property
        (o_clocks_gated && i_ext_irq |-> ##[1:3] !o_clocks_gated)
        else $error("external interrupt did not end stop");
    a_idle_irq_wakes: assert property
        (o_cpu_halt && !o_clocks_gated && i_any_irq |-> ##[1:3] !o_cpu_halt)
        else $error("interrupt did not end idle");
    a_no_crystal_ring: assert property
        (!o_crystal_enable && $past(!o_crystal_enable) && !o_cpu_halt
        && !$past(o_cpu_halt) |-> o_ring_active_flag)
        else $error("cpu runs with crystal off and no ring");
endmodule : pmc_core_chk

bind pmc_core pmc_core_chk #(.XTAL_START_CLOCKS(XTAL_START_CLOCKS)) chk_u (
    .i_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_any_irq,
    .i_ext_irq, .i_rtc_irq, .i_powerfail_irq, .o_cpu_halt, .o_clocks_gated,
    .o_crystal_enable, .o_bandgap_enable, .o_ring_active_flag,
    .o_clock_divide_select, .o_machine_cycle_strobe);

/* tb/pmc_core_tb_top.sv */
// pmc_core_tb_top: self-checking bench for the clock controller
// assumes: pmc_core, pmc_far_model and the bound checker are compiled
`timescale 1ns/1ps
module pmc_core_tb_top;
    localparam int XS = 16;
    localparam logic [9:0] A_PC = pmc_pkg::PMC_ADR_POWER_CONTROL;
    localparam logic [9:0] A_EX = pmc_pkg::PMC_ADR_EXT_FLAG;
    localparam logic [9:0] A_PM = pmc_pkg::PMC_ADR_POWER_MODE;
    localparam logic [9:0] A_ST = pmc_pkg::PMC_ADR_CPU_STATE;
    logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
    logic ack, cg, xe, bg, rg, halt, anyq, ext, rtc, pf, mcs;
    logic [9:0] adr = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic [1:0] div, x, xd;
    logic [6:0] st, r, st_req = 0;
    logic [3:0] irq_req = 0;
    logic [4:0] mon;
    int bad_count = 0, checks = 0, ticks = 0, seed = 32'h290f;
    always #20 clk = ~clk;
    assign mon = {div == 2'h1, xe, rg, cg, halt};
    pmc_core #(.XTAL_START_CLOCKS(XS)) dut_u (.i_clk(clk), .i_resetn(resetn),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_any_irq(anyq), .i_ext_irq(ext), .i_rtc_irq(rtc),
        .i_powerfail_irq(pf), .i_powerfail_in_service(st[6]),
        .i_high_prio_in_service(st[5]), .i_low_prio_in_service(st[4]),
        .i_port1_tx_active(st[3]), .i_port1_rx_active(st[2]),
        .i_port0_tx_active(st[1]), .i_port0_rx_active(st[0]),
        .o_cpu_halt(halt), .o_clocks_gated(cg), .o_crystal_enable(xe),
        .o_bandgap_enable(bg), .o_ring_active_flag(rg),
        .o_clock_divide_select(div), .o_machine_cycle_strobe(mcs));
    pmc_far_model far_u (.i_ring(rg), .i_st_req(st_req), .i_irq_req(irq_req),
        .o_st(st), .o_any_irq(anyq), .o_ext_irq(ext), .o_rtc_irq(rtc),
        .o_pf_irq(pf));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w_en, input logic [9:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w_en; adr <= a; wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 0; stb <= 0; we <= 0;
    endtask : bus
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register", q, {24'h0, e});
    endtask : rd
    task automatic wt(input int s, input logic v);
        for (int n = 0; n < 100 && mon[s] !== v; n++) @(posedge clk);
    endtask : wt
    // strobe to strobe distance in clocks
    task automatic per(input int e);
        int n;
        n = 0;
        while (mcs !== 1'b1) @(posedge clk);
        @(posedge clk);
        while (mcs !== 1'b1 && n < 2 * e) begin
            n++;
            @(posedge clk);
        end
        chk("period", n + 1, e);
    endtask : per
    function automatic logic [1:0] nd(input logic [1:0] c, w);
        return (w == 2'h1 || c == 2'h1) ? w : c;
    endfunction : nd
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        ticks++;
        if (ticks == 12000) begin
            bad_count++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1;
        rd(A_PC, 8'h00);
        rd(A_EX, 8'h08);
        rd(A_PM, 8'h40);
        rd(A_ST, 8'h10);
        rd(10'h3FC, 8'h00);
        repeat (4) begin
            r = 7'($random(seed));
            st_req <= r;
            rd(A_ST, {r[6:4], 1'b1, r[3:0]});
        end
        st_req <= 0;
        xd = 2'h1;
        repeat (8) begin
            x = 2'($random(seed));
            if (x == 2'h0) x = 2'h1;
            bus(1'b1, A_PM, {x, 6'h0});
            xd = nd(xd, x);
            rd(A_PM, {xd, 6'h0});
            chk("divide", div, xd);
        end
        bus(1'b1, A_PM, 8'h40);
        per(pmc_pkg::PMC_CYC_DIV_4);
        bus(1'b1, A_PM, 8'hC0);
        per(pmc_pkg::PMC_CYC_DIV_1024);
        bus(1'b1, A_PM, 8'h40);
        bus(1'b1, A_PM, 8'h80);
        per(pmc_pkg::PMC_CYC_DIV_64);
        irq_req <= 4'h1;
        repeat (8) @(posedge clk);
        irq_req <= 0;
        bus(1'b1, A_PM, 8'hC0);
        rd(A_PM, 8'h80);
        bus(1'b1, A_PM, 8'h40);
        bus(1'b1, A_PM, 8'hA0);
        irq_req <= 4'h1;
        wt(4, 1'b1);
        rd(A_PM, 8'h60);
        irq_req <= 0;
        bus(1'b1, A_PM, 8'h40);
        bus(1'b1, A_PC, 8'h01);
        wt(0, 1'b1);
        chk("gated", cg, 1'b0);
        chk("xtal", xe, 1'b1);
        irq_req <= 4'h1;
        wt(0, 1'b0);
        chk("halt", halt, 1'b0);
        irq_req <= 0;
        bus(1'b1, A_PM, 8'h48);
        rd(A_PM, 8'h40);
        bus(1'b1, A_EX, 8'h00);
        rd(A_EX, 8'h04);
        bus(1'b1, A_PM, 8'h48);
        rd(A_PM, 8'h48);
        wt(3, 1'b0);
        chk("xtal", xe, 1'b0);
        rd(A_ST, 8'h00);
        bus(1'b1, A_EX, 8'h08);
        rd(A_EX, 8'h04);
        bus(1'b1, A_PM, 8'h40);
        repeat (XS + 4) @(posedge clk);
        rd(A_ST, 8'h10);
        bus(1'b1, A_EX, 8'h08);
        rd(A_EX, 8'h08);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, A_EX, {4'h0, 2'h2, k == 0, k == 2});
            bus(1'b1, A_PC, 8'h02);
            wt(1, 1'b1);
            chk("bandgap", bg, k == 2);
            chk("xtal", xe, 1'b0);
            irq_req <= 4'h1;
            repeat (5) @(posedge clk);
            chk("gated", cg, 1'b1);
            irq_req <= 4'h2 << k;
            wt(1, 1'b0);
            irq_req <= 0;
            @(posedge clk);
            chk("ring", rg, k == 0);
            repeat (XS + 8) @(posedge clk);
            chk("ring", rg, 1'b0);
            rd(A_ST, 8'h10);
        end
        complete_run();
    end
endmodule : pmc_core_tb_top
